//--- logic/pyro_link_map.svh
`ifndef PYRO_LINK_MAP_SVH
`define PYRO_LINK_MAP_SVH

// Packet layout: pyro count in the upper half, temperature reference count in the lower half.
`define PKT_W          28
`define COUNT_W        14
`define PYRO_MSB       27
`define PYRO_LSB       14
`define TEMP_MSB       13
`define TEMP_LSB       0
`define BIT_IDX_W      5

// Effective converter range; a pyro count outside it triggers a discharge.
`define RANGE_LOW      14'h01ff
`define RANGE_HIGH     14'h3e01

// Clock periods in nanoseconds.
`define CORE_CLK_NS    20
`define LINK_CLK_NS    80

// Link timing in nanoseconds.
`define FORCED_HIGH_NS 110000
`define ABORT_LOW_NS   145000
`define READY_PULSE_NS 75000
`define STROBE_MAX_NS  2000
`define BIT_HOLD_NS    6000

// Core timing in nanoseconds.
`define SAMPLE_TIMEOUT_NS 14600000
`define DISCHARGE_NS      16000000

// Counter widths.
`define LINK_CNT_W     12
`define CORE_CNT_W     24

`endif

//--- logic/pyro_link_pkg.sv
`default_nettype none
`include "pyro_link_map.svh"

package pyro_link_pkg;

   typedef logic [`PKT_W-1:0]      pkt_t;
   typedef logic [`COUNT_W-1:0]    count_t;
   typedef logic [`LINK_CNT_W-1:0] link_cnt_t;
   typedef logic [`CORE_CNT_W-1:0] core_cnt_t;
   typedef logic [`BIT_IDX_W-1:0]  bit_idx_t;

   // States of the wire-facing sequencer.
   typedef enum logic [2:0] {
      L_IDLE,
      L_READY,
      L_ARMED,
      L_STROBE,
      L_DRIVE
   } link_state_e;

   // All state of the link clock domain.
   typedef struct packed {
      link_state_e state;
      link_cnt_t   cnt;
      bit_idx_t    bit_idx;
      pkt_t        shreg;
      pkt_t        pkt;
      logic        req_seen;
      logic        rdy_seen;
      logic        start_tgl;
      logic        line_prev;
      logic        line_out;
      logic        line_oe;
   } link_s;

   // All state of the core clock domain.
   typedef struct packed {
      pkt_t      snap;
      logic      snap_req;
      logic      rdy_tgl;
      logic      start_seen;
      core_cnt_t tmr;
      core_cnt_t dis_cnt;
      logic      discharge;
   } core_s;

   // Converts a least time into whole clock cycles, rounding up, never below one.
   function automatic int unsigned cyc_ceil(input int unsigned ns, input int unsigned per);
      int unsigned c;
      c = (ns + per - 1) / per;
      return (c == 0) ? 1 : c;
   endfunction

endpackage

`default_nettype wire

//--- logic/bit_sync2.sv
`default_nettype none

// Two-flop synchroniser for independent single-bit levels.
module bit_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule // bit_sync2

`default_nettype wire

//--- logic/pyro_one_wire_readout.sv
// Operation
// - Packet: pyro count high, temperature count low.
// - Both counts are 14-bit unsigned values.
// - Out-of-range pyro count shorts input about 16ms.
// - Every exchange begins with line rising.
// - Sensor starts readouts itself when host idles.
// - No host start for 14.6ms: sensor pulses.
// - Sensor ready pulse recurs, 14.6ms apart.
// - Device waits host rising edge per bit.
// - Device pulls low for 0, leaves 1.
// - Driven bit level settles within 2us.
`default_nettype none
`include "pyro_link_map.svh"

module pyro_one_wire_readout
   import pyro_link_pkg::*;
#(
   parameter int unsigned SAMPLE_TIMEOUT_CYC = cyc_ceil(`SAMPLE_TIMEOUT_NS, `CORE_CLK_NS),
   parameter int unsigned DISCHARGE_CYC      = cyc_ceil(`DISCHARGE_NS, `CORE_CLK_NS)
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         link_clk,
   input  wire logic         sample_valid,
   input  wire logic [13:0]  pyro_channel_count,
   input  wire logic [13:0]  temperature_reference_count,
   input  wire logic         line_in,
   output logic              line_out,
   output logic              line_oe,
   output logic              discharge
);

   // Core-domain counts, reduced to the counter width.
   localparam core_cnt_t TMO_LAST = core_cnt_t'(SAMPLE_TIMEOUT_CYC - 1);
   localparam core_cnt_t DIS_LEN  = core_cnt_t'(DISCHARGE_CYC);

   // Link-domain counts.
   localparam link_cnt_t FORCED_CYC  = link_cnt_t'(cyc_ceil(`FORCED_HIGH_NS, `LINK_CLK_NS));
   localparam link_cnt_t ABORT_LAST  = link_cnt_t'(cyc_ceil(`ABORT_LOW_NS, `LINK_CLK_NS) - 1);
   localparam link_cnt_t READY_LAST  = link_cnt_t'(cyc_ceil(`READY_PULSE_NS, `LINK_CLK_NS) - 1);
   localparam link_cnt_t STROBE_LAST = link_cnt_t'(cyc_ceil(`STROBE_MAX_NS, `LINK_CLK_NS) - 1);
   localparam link_cnt_t HOLD_LAST   = link_cnt_t'(cyc_ceil(`BIT_HOLD_NS, `LINK_CLK_NS) - 1);
   localparam bit_idx_t  LAST_BIT    = bit_idx_t'(`PKT_W - 1);

   core_s cq;
   core_s cd;
   link_s lq;
   link_s ld;

   // Synchronised views of the other domain.
   logic line_s;
   logic req_s;
   logic rdy_s;
   logic start_s;
   logic ack_s;

   // Returns true when a pyro count leaves the usable converter range.
   function automatic logic out_of_range(input count_t c);
      return (c < `RANGE_LOW) || (c > `RANGE_HIGH);
   endfunction

   // Line, snapshot request and ready request enter the link domain.
   bit_sync2 #(
      .W (3)
   ) u_link_sync (
      .clk   (link_clk),
      .rst_n (rst_n),
      .d     ({line_in, cq.snap_req, cq.rdy_tgl}),
      .q     ({line_s, req_s, rdy_s})
   );

   // Start notice and snapshot acknowledge enter the core domain.
   bit_sync2 #(
      .W (2)
   ) u_core_sync (
      .clk   (clock),
      .rst_n (rst_n),
      .d     ({lq.start_tgl, lq.req_seen}),
      .q     ({start_s, ack_s})
   );

   // ------------------------------------------------------------------
   // Core domain: sample capture, ready-pulse pacing and discharge.
   // ------------------------------------------------------------------

   // Next-state logic of the core domain.
   always_comb begin
      cd = cq;

      // A host-forced start restarts the pacing timer; otherwise the timer
      // expiring asks the link side for a ready pulse and starts over.
      if (start_s != cq.start_seen) begin
         cd.start_seen = start_s;
         cd.tmr        = '0;
      end else if (cq.tmr == TMO_LAST) begin
         cd.tmr     = '0;
         cd.rdy_tgl = ~cq.rdy_tgl;
      end else begin
         cd.tmr = cq.tmr + core_cnt_t'(1);
      end

      // A new sample is published only once the link side has taken the last
      // one, so the snapshot never changes while it is being copied across.
      if (sample_valid && (cq.snap_req == ack_s)) begin
         cd.snap[`PYRO_MSB:`PYRO_LSB] = pyro_channel_count;
         cd.snap[`TEMP_MSB:`TEMP_LSB] = temperature_reference_count;
         cd.snap_req                  = ~cq.snap_req;
      end

      // Discharge window; a fresh out-of-range sample retriggers it.
      if (sample_valid && out_of_range(pyro_channel_count)) begin
         cd.discharge = 1'b1;
         cd.dis_cnt   = DIS_LEN;
      end else if (cq.discharge) begin
         cd.dis_cnt = cq.dis_cnt - core_cnt_t'(1);
         if (cq.dis_cnt == core_cnt_t'(1)) begin
            cd.discharge = 1'b0;
         end
      end
   end

   // Core-domain state register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cq <= '0;
      end else begin
         cq <= cd;
      end
   end

   // ------------------------------------------------------------------
   // Link domain: start detection, ready pulse and bit shifting.
   // ------------------------------------------------------------------

   // Next-state logic of the link domain.
   always_comb begin
      ld           = lq;
      ld.line_prev = line_s;

      // A ready request seen while busy is dropped; the next one follows.
      if (rdy_s != lq.rdy_seen) begin
         ld.rdy_seen = rdy_s;
      end

      unique case (lq.state)
         L_IDLE: begin
            ld.line_oe = 1'b0;
            // Take a newly published sample; the core holds it steady.
            if (req_s != lq.req_seen) begin
               ld.pkt      = cq.snap;
               ld.req_seen = req_s;
            end
            // Measure how long the host has held the line high.
            if (line_s) begin
               if (lq.cnt != FORCED_CYC) begin
                  ld.cnt = lq.cnt + link_cnt_t'(1);
               end
            end else begin
               ld.cnt = '0;
            end
            if (!line_s && lq.line_prev && (lq.cnt == FORCED_CYC)) begin
               // Long high then low: a forced start.
               ld.state     = L_ARMED;
               ld.shreg     = lq.pkt;
               ld.bit_idx   = '0;
               ld.cnt       = '0;
               ld.start_tgl = ~lq.start_tgl;
            end else if ((rdy_s != lq.rdy_seen) && !line_s) begin
               // Raise the line to announce a ready sample.
               ld.state    = L_READY;
               ld.line_out = 1'b1;
               ld.line_oe  = 1'b1;
               ld.cnt      = '0;
            end
         end

         L_READY: begin
            ld.cnt = lq.cnt + link_cnt_t'(1);
            if (lq.cnt == READY_LAST) begin
               // Release; the host now pulls low and strobes bits.
               ld.line_oe = 1'b0;
               ld.state   = L_ARMED;
               ld.shreg   = lq.pkt;
               ld.bit_idx = '0;
               ld.cnt     = '0;
            end
         end

         L_ARMED: begin
            if (line_s && !lq.line_prev) begin
               ld.state = L_STROBE;
               ld.cnt   = '0;
            end else if (!line_s) begin
               ld.cnt = lq.cnt + link_cnt_t'(1);
               if (lq.cnt == ABORT_LAST) begin
                  // Long low: the host has cancelled the readout.
                  ld.state = L_IDLE;
                  ld.cnt   = '0;
               end
            end else begin
               ld.cnt = '0;
            end
         end

         L_STROBE: begin
            // Stay off the wire for the longest host strobe.
            ld.cnt = lq.cnt + link_cnt_t'(1);
            if (lq.cnt == STROBE_LAST) begin
               ld.state = L_DRIVE;
               ld.cnt   = '0;
               if (!lq.shreg[`PKT_W-1]) begin
                  ld.line_out = 1'b0;
                  ld.line_oe  = 1'b1;
               end
            end
         end

         L_DRIVE: begin
            // Hold the bit well past its settling time, then release.
            ld.cnt = lq.cnt + link_cnt_t'(1);
            if (lq.cnt == HOLD_LAST) begin
               ld.line_oe = 1'b0;
               ld.shreg   = {lq.shreg[`PKT_W-2:0], 1'b0};
               ld.cnt     = '0;
               if (lq.bit_idx == LAST_BIT) begin
                  ld.state = L_IDLE;
               end else begin
                  ld.bit_idx = lq.bit_idx + bit_idx_t'(1);
                  ld.state   = L_ARMED;
               end
            end
         end
      endcase
   end

   // Link-domain state register.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   // Outputs come straight from state flops.
   assign line_out  = lq.line_out;
   assign line_oe   = lq.line_oe;
   assign discharge = cq.discharge;

endmodule // pyro_one_wire_readout

`default_nettype wire

//--- verif/pyro_one_wire_readout_monitor.sv
`default_nettype none
`include "pyro_link_map.svh"

module pyro_one_wire_readout_monitor #(
   parameter int unsigned SAMPLE_TIMEOUT_CYC = 1,
   parameter int unsigned DISCHARGE_CYC      = 1
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        link_clk,
   input wire logic        sample_valid,
   input wire logic [13:0] pyro_channel_count,
   input wire logic [13:0] temperature_reference_count,
   input wire logic        line_in,
   input wire logic        line_out,
   input wire logic        line_oe,
   input wire logic        discharge
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        oor;
   logic [23:0] dcnt_q;
   logic [11:0] ocnt_q;
   // A sample outside the usable converter range.
   assign oor = sample_valid
                && (pyro_channel_count < `RANGE_LOW || pyro_channel_count > `RANGE_HIGH);
   // Age of the discharge window; zero one cycle after the window is over.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) dcnt_q <= '0;
      else if (oor) dcnt_q <= 24'h1;
      else if (dcnt_q != 0 && dcnt_q <= 24'(DISCHARGE_CYC)) dcnt_q <= dcnt_q + 24'h1;
      else dcnt_q <= '0;
   end
   // Length of the current drive of the wire.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) ocnt_q <= '0;
      else ocnt_q <= line_oe ? ocnt_q + 12'h1 : '0;
   end
   sequence zero_start;
      $rose(line_oe) && !line_out;
   endsequence
   sequence ready_start;
      $rose(line_oe) && line_out;
   endsequence
   dis_start_a: assert property (@(posedge clock) disable iff (!rst_n) oor |=> discharge)
      else $error("discharge did not start");
   dis_window_a: assert property (@(posedge clock) disable iff (!rst_n)
      discharge == (dcnt_q != 0 && dcnt_q <= 24'(DISCHARGE_CYC)))
      else $error("discharge window length wrong");
   dis_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
      sample_valid && !oor && !discharge |=> !discharge)
      else $error("discharge on in-range sample");
   drive_len_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $fell(line_oe) |-> ocnt_q == ($past(line_out) ? 12'h3aa : 12'h04b))
      else $error("drive length wrong");
   drive_level_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      line_oe && $past(line_oe) |-> $stable(line_out))
      else $error("driven level changed");
   zero_strobe_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      zero_start |-> $past(line_in) && $past(line_in, 8) && $past(line_in, 20))
      else $error("zero bit without host strobe");
   zero_gap_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $fell(line_oe) && !$past(line_out) |-> !line_oe [*8])
      else $error("zero bit driven again too soon");
   ready_line_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      ready_start |-> !$past(line_in) && !$past(line_in, 4))
      else $error("ready pulse while line high");
endmodule // pyro_one_wire_readout_monitor

bind pyro_one_wire_readout pyro_one_wire_readout_monitor #(
   .SAMPLE_TIMEOUT_CYC(SAMPLE_TIMEOUT_CYC), .DISCHARGE_CYC(DISCHARGE_CYC)
) mon (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .sample_valid(sample_valid),
   .pyro_channel_count(pyro_channel_count), .line_in(line_in), .line_out(line_out),
   .temperature_reference_count(temperature_reference_count), .line_oe(line_oe),
   .discharge(discharge));

`default_nettype wire

//--- verif/pyro_host_model.sv
`default_nettype none

module pyro_host_model
   import pyro_link_pkg::*;
(
   input  wire logic wire_lvl,
   output var logic  host_out,
   output var logic  host_oe,
   output var logic  got,
   output var pkt_t  got_pkt
);
   timeunit 1ns;
   timeprecision 1ps;
   // The host listens with its pin released until it acts.
   initial begin
      host_out = 1'b0;
      host_oe = 1'b0;
      got = 1'b0;
      got_pkt = '0;
   end
   // Drives the wire to a level for a time in nanoseconds.
   task automatic drive(input logic lvl, input int unsigned ns);
      host_out = lvl;
      host_oe = 1'b1;
      #(ns);
   endtask
   // Releases the wire to high impedance.
   task automatic float_line();
      host_oe = 1'b0;
   endtask
   // Forced start: long high, then low before the first strobe.
   task automatic forced_start();
      drive(1'b1, 112000);
      drive(1'b0, 2000);
   endtask
   // Reads n bits, MSB first, 12 us per bit, and reports them right-justified.
   task automatic read_bits(input int n);
      pkt_t sh;
      sh = '0;
      repeat (n) begin
         drive(1'b1, 1000);
         host_oe = 1'b0;
         #4000;
         sh = {sh[26:0], wire_lvl};
         drive(1'b0, 7000);
      end
      float_line();
      got_pkt = sh;
      got = 1'b1;
      #20;
      got = 1'b0;
   endtask
endmodule // pyro_host_model

`default_nettype wire

//--- verif/test_pyro_one_wire_readout.sv
`default_nettype none
`include "pyro_link_map.svh"

module test_pyro_one_wire_readout
   import pyro_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TMO = 25000;
   localparam int unsigned DIS = 500;
   logic        clock;
   logic        link_clk;
   logic        rst_n;
   logic        sample_valid;
   logic [13:0] pyro;
   logic [13:0] temp;
   logic        wire_lvl = 1'b0;
   logic        line_out, line_oe, discharge, host_out, host_oe, got;
   pkt_t        got_pkt;
   pkt_t        exp_q[$];
   int          n_fail = 0;
   int          tests_run = 0;
   // Core clock 50 MHz and an unrelated 12.5 MHz link clock.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #40 link_clk = ~link_clk;
   end
   // Wire: device first, then host, else a keeper holds the last level.
   always @* begin
      if (line_oe) wire_lvl = line_out;
      else if (host_oe) wire_lvl = host_out;
   end
   pyro_one_wire_readout #(.SAMPLE_TIMEOUT_CYC(TMO), .DISCHARGE_CYC(DIS)) DUT (
      .clock(clock), .rst_n(rst_n), .link_clk(link_clk), .sample_valid(sample_valid),
      .pyro_channel_count(pyro), .temperature_reference_count(temp), .line_in(wire_lvl),
      .line_out(line_out), .line_oe(line_oe), .discharge(discharge));
   pyro_host_model host (.wire_lvl(wire_lvl), .host_out(host_out), .host_oe(host_oe),
      .got(got), .got_pkt(got_pkt));
   // Counts a comparison and reports a mismatch.
   task automatic check(input string what, input pkt_t exp, input pkt_t seen);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Compares a single flag.
   task automatic check_bit(input string what, input logic exp, input logic seen);
      check(what, {27'h0, exp}, {27'h0, seen});
   endtask
   // Presents one sample and checks the discharge flag it causes.
   task automatic sample(input logic [13:0] p, input logic [13:0] t);
      @(negedge clock);
      pyro = p;
      temp = t;
      sample_valid = 1'b1;
      @(negedge clock);
      sample_valid = 1'b0;
      @(negedge clock);
      check_bit("discharge", p < `RANGE_LOW || p > `RANGE_HIGH, discharge);
      #2000;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Each read reported by the host is matched with the oldest note.
   always @(posedge got) begin
      if (exp_q.size() == 0) check("unexpected packet", '0, ~got_pkt);
      else check("packet", exp_q.pop_front(), got_pkt);
   end
   // Cuts a hang short; the tests need about 1.35 ms, so this stays under 100000 cycles.
   initial begin
      #1900000;
      n_fail++;
      summarize();
   end
   // Forced readout, sensor-started readout, then an abort in mid-packet.
   initial begin
      logic [13:0] t;
      rst_n = 1'b0;
      sample_valid = 1'b0;
      pyro = '0;
      temp = '0;
      void'($urandom(53));
      repeat (20) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      repeat (10) @(posedge link_clk);
      t = 14'($urandom);
      sample(14'h01ff, t);
      exp_q.push_back({14'h01ff, t});
      host.forced_start();
      host.read_bits(28);
      t = 14'($urandom);
      sample(14'h3e02, t);
      exp_q.push_back({14'h3e02, t});
      for (int i = 0; i < 40000 && line_oe !== 1'b1; i++) @(posedge clock);
      check_bit("ready pulse", 1'b1, line_oe && line_out);
      for (int i = 0; i < 5000 && line_oe !== 1'b0; i++) @(posedge clock);
      check_bit("ready end", 1'b0, line_oe);
      host.drive(1'b0, 2000);
      host.read_bits(28);
      sample(14'h3e01, 14'($urandom));
      t = 14'($urandom);
      sample(14'h0000, t);
      exp_q.push_back(28'h0);
      exp_q.push_back(28'h1);
      host.forced_start();
      host.read_bits(3);
      host.drive(1'b0, 146000);
      host.float_line();
      host.read_bits(1);
      summarize();
   end
endmodule // test_pyro_one_wire_readout

`default_nettype wire
